// >>> pkg/wel_pkg.sv
// Constants shared by the wake event and line enable logic.
// Assumes a 10 MHz reference clock and a 32-bit classic Wishbone master.
// How it works
// - Pin mode: wake detect output asserts on every valid line wake-up.
// - Bus mode, pulse mask 1: wake pulses request pin low if no flags.
// - Bus mode, pulse mask 0: wake sets flag; request held until flags read.
// - Bus mode: request pin low while any event flag set or on wake.
// - Pin mode: request pin low while thermal or overcurrent fault exists.
// - Request pin is open-drain, active low, never driven high.
// - Bus mode: driver off at start; on only with enable bit and transmit pin.
// - Pin mode: host raises transmit pin; driver follows that pin while enable pin high.
// - Bus mode: aux input on at power-up; off when the off bit set.
// - Pin mode: aux input always enabled, nothing can turn it off.
// - Enable pin low: driver off; bus mode registers held at reset.
// - Aux logic output shows the inverse of the sensed aux level.
`default_nettype none
package wel_pkg;
  // Bus decode: byte addresses
  localparam logic [3:0] WEL_CTRL_ADDR = 4'h0;
  localparam logic [3:0] WEL_FLAGS_ADDR = 4'h4;
  localparam logic [3:0] WEL_MASK_ADDR = 4'h8;
  localparam logic [3:0] WEL_STATUS_ADDR = 4'hC;
  // Control register fields
  localparam int WEL_CTRL_DRV_EN_BIT = 0;
  localparam int WEL_CTRL_AUX_OFF_BIT = 1;
  localparam logic [1:0] WEL_CTRL_RESET = 2'h0;
  // Flag and mask layout
  localparam int WEL_FLAG_WAKE_BIT = 0;
  localparam int WEL_FLAG_THERM_BIT = 1;
  localparam int WEL_FLAG_OVERCUR_BIT = 2;
  localparam int WEL_MASK_PULSE_BIT = 3;
  localparam logic [2:0] WEL_FLAGS_RESET = 3'h0;
  localparam logic [3:0] WEL_MASK_RESET = 4'h0;
  // Synchronised pin positions
  localparam int WEL_SYNC_W = 7;
  localparam int WEL_PIN_MODE = 0;
  localparam int WEL_PIN_EN_GOOD = 1;
  localparam int WEL_PIN_TX_EN = 2;
  localparam int WEL_PIN_AUX = 3;
  localparam int WEL_PIN_WAKE = 4;
  localparam int WEL_PIN_THERM = 5;
  localparam int WEL_PIN_OVERCUR = 6;
  localparam logic [6:0] WEL_SYNC_RESET = 7'h00;
  // Timing
  localparam int WEL_CLK_PERIOD_NS = 100;
  localparam int WEL_WAKE_PULSE_LOW_TIME_NS = 100000;
  localparam logic [9:0] WEL_WAKE_PULSE_CYC =
    10'((WEL_WAKE_PULSE_LOW_TIME_NS + WEL_CLK_PERIOD_NS - 1) / WEL_CLK_PERIOD_NS);
  localparam logic [9:0] WEL_TIMER_RESET = 10'h000;
  localparam logic [31:0] WEL_DATA_ZERO = 32'h0000_0000;
endpackage : wel_pkg
`default_nettype wire

// >>> rtl/wel_top.sv
// Wake event signalling and line enable control with a Wishbone register file.
// Assumes pins arrive asynchronously and a classic Wishbone master on REF_CLK_I.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module wel_top
  import wel_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic BUS_MODE_I,
  input wire logic ENABLE_GOOD_I,
  input wire logic LINE_TX_EN_I,
  input wire logic AUX_LEVEL_I,
  input wire logic WAKE_SEEN_I,
  input wire logic THERMAL_FAULT_I,
  input wire logic OVERCURRENT_FAULT_I,
  output logic WAKE_REQ_N_O,
  output logic WAKE_REQ_OE_O,
  output logic WAKE_DETECT_O,
  output logic WAKE_DETECT_OE_O,
  output logic LINE_DRIVER_EN_O,
  output logic AUX_RX_EN_O,
  output logic AUX_LOGIC_O,
  output logic AUX_LOGIC_OE_O,
  output logic IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [WEL_SYNC_W-1:0] pins_raw;
  logic [WEL_SYNC_W-1:0] sync1_q;
  logic [WEL_SYNC_W-1:0] sync2_q;
  logic wake_prev_q;
  logic wake_prev_d;

  assign pins_raw = {OVERCURRENT_FAULT_I, THERMAL_FAULT_I, WAKE_SEEN_I,
                     AUX_LEVEL_I, LINE_TX_EN_I, ENABLE_GOOD_I, BUS_MODE_I};

  genvar g;
  generate
    for (g = 0; g < WEL_SYNC_W; g++) begin : g_sync
      always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          sync1_q[g] <= WEL_SYNC_RESET[g];
          sync2_q[g] <= WEL_SYNC_RESET[g];
        end else begin
          sync1_q[g] <= pins_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  logic bus_mode;
  logic en_good;
  logic tx_en;
  logic aux_level;
  logic therm;
  logic overcur;
  logic wake_evt;

  assign bus_mode = sync2_q[WEL_PIN_MODE];
  assign en_good = sync2_q[WEL_PIN_EN_GOOD];
  assign tx_en = sync2_q[WEL_PIN_TX_EN];
  assign aux_level = sync2_q[WEL_PIN_AUX];
  assign therm = sync2_q[WEL_PIN_THERM];
  assign overcur = sync2_q[WEL_PIN_OVERCUR];
  assign wake_evt = sync2_q[WEL_PIN_WAKE] & ~wake_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic bus_req;
  logic wr_take;
  logic rd_take;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [9:0] timer_q;
  logic [9:0] timer_d;
  logic pulse_on;
  logic [31:0] status_word;

  assign bus_req = CYC_I & STB_I & ~ack_q;
  assign wr_take = bus_req & WE_I & SEL_I[0];
  assign rd_take = bus_req & ~WE_I;
  assign pulse_on = (timer_q != WEL_TIMER_RESET);

  assign status_word = {22'h000000, pulse_on, LINE_DRIVER_EN_O, aux_level,
                        overcur, therm, sync2_q[WEL_PIN_WAKE], tx_en,
                        en_good, bus_mode, 1'h0};

  always_comb begin
    ack_d = bus_req;
    dat_d = WEL_DATA_ZERO;
    if (rd_take) begin
      unique case (ADR_I)
        WEL_CTRL_ADDR: dat_d = {30'h00000000, ctrl_q};
        WEL_FLAGS_ADDR: dat_d = {29'h00000000, flags_q};
        WEL_MASK_ADDR: dat_d = {28'h0000000, mask_q};
        WEL_STATUS_ADDR: dat_d = status_word;
        default: dat_d = WEL_DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      dat_q <= WEL_DATA_ZERO;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and event flags

  logic flags_rd;
  logic [2:0] flag_set;
  logic wake_to_pulse;

  assign flags_rd = rd_take & (ADR_I == WEL_FLAGS_ADDR);
  assign wake_to_pulse = bus_mode & wake_evt & mask_q[WEL_MASK_PULSE_BIT]
                         & (flags_q == WEL_FLAGS_RESET);

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    flags_d = flags_q;
    flag_set = 3'h0;
    timer_d = timer_q;
    wake_prev_d = sync2_q[WEL_PIN_WAKE];
    if (wr_take && ADR_I == WEL_CTRL_ADDR) begin
      ctrl_d = DAT_I[1:0];
    end
    if (wr_take && ADR_I == WEL_MASK_ADDR) begin
      mask_d = DAT_I[3:0];
    end
    if (bus_mode) begin
      flag_set[WEL_FLAG_WAKE_BIT] = wake_evt & ~mask_q[WEL_MASK_PULSE_BIT];
      flag_set[WEL_FLAG_THERM_BIT] = therm;
      flag_set[WEL_FLAG_OVERCUR_BIT] = overcur;
    end
    // Set wins over the read clear
    if (flags_rd) begin
      flags_d = WEL_FLAGS_RESET;
    end
    flags_d = flags_d | flag_set;
    // Wake pulse timer, used by both modes
    if (wake_to_pulse || (!bus_mode && wake_evt)) begin
      timer_d = WEL_WAKE_PULSE_CYC;
    end else if (pulse_on) begin
      timer_d = timer_q - 10'h001;
    end
    if (!en_good) begin
      ctrl_d = WEL_CTRL_RESET;
      mask_d = WEL_MASK_RESET;
      flags_d = WEL_FLAGS_RESET;
      timer_d = WEL_TIMER_RESET;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= WEL_CTRL_RESET;
      mask_q <= WEL_MASK_RESET;
      flags_q <= WEL_FLAGS_RESET;
      timer_q <= WEL_TIMER_RESET;
      wake_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      flags_q <= flags_d;
      timer_q <= timer_d;
      wake_prev_q <= wake_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  logic req_oe_d;
  logic req_oe_q;
  logic det_d;
  logic det_q;
  logic drv_d;
  logic drv_q;
  logic aux_en_d;
  logic aux_en_q;
  logic aux_out_q;
  logic irq_d;
  logic irq_q;
  logic pulse_next;

  assign pulse_next = (timer_d != WEL_TIMER_RESET);

  always_comb begin
    if (bus_mode) begin
      req_oe_d = (flags_d != WEL_FLAGS_RESET) | pulse_next;
      det_d = 1'b0;
      drv_d = ctrl_d[WEL_CTRL_DRV_EN_BIT] & tx_en;
      aux_en_d = ~ctrl_d[WEL_CTRL_AUX_OFF_BIT];
    end else begin
      req_oe_d = therm | overcur;
      det_d = pulse_next;
      drv_d = tx_en;
      aux_en_d = 1'b1;
    end
    if (!en_good) begin
      drv_d = 1'b0;
    end
    irq_d = |(flags_d & mask_d[2:0]);
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_oe_q <= 1'b0;
      det_q <= 1'b0;
      drv_q <= 1'b0;
      aux_en_q <= 1'b1;
      aux_out_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      req_oe_q <= req_oe_d;
      det_q <= det_d;
      drv_q <= drv_d;
      aux_en_q <= aux_en_d;
      aux_out_q <= ~aux_level;
      irq_q <= irq_d;
    end
  end

  // Open-drain request: level is held low, only the enable moves
  logic req_level_q;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_level_q <= 1'b0;
    end else begin
      req_level_q <= 1'b0;
    end
  end

  logic det_oe_q;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      det_oe_q <= 1'b0;
    end else begin
      det_oe_q <= ~bus_mode;
    end
  end

  assign WAKE_REQ_N_O = req_level_q;
  assign WAKE_REQ_OE_O = req_oe_q;
  assign WAKE_DETECT_O = det_q;
  assign WAKE_DETECT_OE_O = det_oe_q;
  assign LINE_DRIVER_EN_O = drv_q;
  assign AUX_RX_EN_O = aux_en_q;
  assign AUX_LOGIC_O = aux_out_q;
  assign AUX_LOGIC_OE_O = aux_en_q;
  assign IRQ_O = irq_q;
  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_pin_wake_detect: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!bus_mode && en_good && wake_evt) |=> det_d ##1 WAKE_DETECT_O)
    else $error("wake detect missing in pin mode");

  chk_wake_pulse_len: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (wake_to_pulse && en_good) |=> (timer_q == WEL_WAKE_PULSE_CYC))
    else $error("wake pulse timer not loaded");

  chk_wake_flag_set: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (bus_mode && en_good && wake_evt && !mask_q[WEL_MASK_PULSE_BIT])
    |=> flags_q[WEL_FLAG_WAKE_BIT])
    else $error("wake flag not set");

  chk_req_on_flags: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    ($past(bus_mode) && flags_q != WEL_FLAGS_RESET) |-> WAKE_REQ_OE_O)
    else $error("request pin released while flags set");

  chk_req_on_fault: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!bus_mode && (therm || overcur)) |=> WAKE_REQ_OE_O)
    else $error("fault not shown on request pin");

  chk_req_never_high: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    !WAKE_REQ_N_O)
    else $error("request pin driven high");

  chk_drv_gate: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (bus_mode && !ctrl_q[WEL_CTRL_DRV_EN_BIT] && !ctrl_d[WEL_CTRL_DRV_EN_BIT])
    |=> !LINE_DRIVER_EN_O)
    else $error("driver on without enable bit");

  chk_drv_pin_mode: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!bus_mode && en_good) |=> (LINE_DRIVER_EN_O == $past(tx_en)))
    else $error("driver not following transmit pin");

  chk_aux_off: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (bus_mode && ctrl_d[WEL_CTRL_AUX_OFF_BIT]) |=> !AUX_RX_EN_O)
    else $error("aux input not turned off");

  chk_aux_pin_mode: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    !bus_mode |=> AUX_RX_EN_O)
    else $error("aux input off in pin mode");

  chk_disable_hold: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    !en_good |=> (!LINE_DRIVER_EN_O && flags_q == WEL_FLAGS_RESET
                  && ctrl_q == WEL_CTRL_RESET))
    else $error("state not held while disabled");

  chk_aux_invert: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    !RST_I |=> (AUX_LOGIC_O == !$past(aux_level)))
    else $error("aux logic not inverted");

  chk_read_clears: assert property (
    @(posedge REF_CLK_I) disable iff (RST_I)
    (flags_rd && en_good) |=> (flags_q == $past(flag_set)))
    else $error("flag read did not clear");

endmodule : wel_top
`default_nettype wire

// >>> tb/wake_event_and_line_enable_logic_test.sv
// Self-checking bench for the wake event and line enable logic.
// Assumes wel_top, wel_pkg and wel_line_model on a 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module wake_event_and_line_enable_logic_test import wel_pkg::*;;
  logic clk, rst, cyc, stb, we, mode, eng, aux, thm, ocr, go, txr, wk, tx, ack;
  logic rq_n, rq_oe, det, det_oe, drv, aux_en, aux_lo, aux_oe, irq, pin;
  logic [3:0] adr;
  logic [31:0] wd, rd, dq;
  int n_fail = 0;
  int compares = 0;
  // Pull-up on the request pin
  assign pin = rq_oe ? rq_n : 1'b1;
  wel_top uut (
    .REF_CLK_I(clk),
    .RST_I(rst),
    .CYC_I(cyc),
    .STB_I(stb),
    .WE_I(we),
    .ADR_I(adr),
    .SEL_I(4'hF),
    .DAT_I(wd),
    .DAT_O(dq),
    .ACK_O(ack),
    .BUS_MODE_I(mode),
    .ENABLE_GOOD_I(eng),
    .LINE_TX_EN_I(tx),
    .AUX_LEVEL_I(aux),
    .WAKE_SEEN_I(wk),
    .THERMAL_FAULT_I(thm),
    .OVERCURRENT_FAULT_I(ocr),
    .WAKE_REQ_N_O(rq_n),
    .WAKE_REQ_OE_O(rq_oe),
    .WAKE_DETECT_O(det),
    .WAKE_DETECT_OE_O(det_oe),
    .LINE_DRIVER_EN_O(drv),
    .AUX_RX_EN_O(aux_en),
    .AUX_LOGIC_O(aux_lo),
    .AUX_LOGIC_OE_O(aux_oe),
    .IRQ_O(irq)
  );
  wel_line_model line (
    .clk_i(clk),
    .go_i(go),
    .tx_i(txr),
    .wake_o(wk),
    .tx_o(tx)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial begin
    #(100 * 8000);
    n_fail++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    chk(ack, 1'b1);
    rd = dq;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic fire;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(10);
  endtask : fire
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    txr <= 1'b1;
    bus(1'b1, WEL_CTRL_ADDR, 32'h1);
    tick(8);
    chk(drv, 1'b1);
    bus(1'b0, WEL_STATUS_ADDR, 32'h0);
    chk(rd, 32'h0000_010E);
    txr <= 1'b0;
    aux <= 1'b1;
    tick(8);
    chk(drv, 1'b0);
    chk(aux_lo, 1'b0);
    bus(1'b1, WEL_CTRL_ADDR, 32'h3);
    tick(4);
    chk(aux_en, 1'b0);
    chk(aux_oe, 1'b0);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    txr <= 1'b1;
    eng <= 1'b0;
    tick(8);
    chk(drv, 1'b0);
    eng <= 1'b1;
    tick(4);
    bus(1'b0, WEL_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(aux_en, 1'b1);
    txr <= 1'b0;
    $display("register test done");
  endtask : t_regs
  task automatic t_flag;
    bus(1'b1, WEL_MASK_ADDR, 32'h0);
    fire;
    chk(pin, 1'b0);
    chk(irq, 1'b0);
    bus(1'b1, WEL_MASK_ADDR, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    chk(pin, 1'b0);
    bus(1'b0, WEL_FLAGS_ADDR, 32'h0);
    chk(rd, 32'h1);
    tick(3);
    chk(pin, 1'b1);
    chk(irq, 1'b0);
    $display("flag test done");
  endtask : t_flag
  task automatic t_pulse;
    int n;
    n = 0;
    bus(1'b1, WEL_MASK_ADDR, 32'h8);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    repeat (20) if (rq_oe !== 1'b1) @(posedge clk);
    chk(pin, 1'b0);
    chk(rq_n, 1'b0);
    while (rq_oe === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
    end
    chk(32'(n), 32'(WEL_WAKE_PULSE_CYC));
    bus(1'b0, WEL_FLAGS_ADDR, 32'h0);
    chk(rd, 32'h0);
    thm <= 1'b1;
    tick(8);
    thm <= 1'b0;
    tick(8);
    fire;
    bus(1'b0, WEL_FLAGS_ADDR, 32'h0);
    chk(rd, 32'h2);
    tick(3);
    chk(pin, 1'b1);
    $display("pulse test done");
  endtask : t_pulse
  task automatic t_pin;
    mode <= 1'b0;
    txr <= 1'b1;
    bus(1'b1, WEL_CTRL_ADDR, 32'h2);
    tick(8);
    chk(aux_en, 1'b1);
    chk(drv, 1'b1);
    fire;
    chk(det, 1'b1);
    chk(det_oe, 1'b1);
    for (int i = 0; i < 2; i++) begin
      thm <= (i == 0);
      ocr <= (i == 1);
      tick(8);
      chk(pin, 1'b0);
      thm <= 1'b0;
      ocr <= 1'b0;
      tick(8);
      chk(pin, 1'b1);
    end
    $display("pin mode test done");
  endtask : t_pin
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, mode, eng} = 3'h7;
    {cyc, stb, we, aux, thm, ocr, go, txr} = 8'h00;
    adr = 4'h0;
    wd = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(4);
    chk(drv, 1'b0);
    chk(aux_en, 1'b1);
    chk(pin, 1'b1);
    t_regs;
    t_flag;
    t_pulse;
    t_pin;
    finish_test;
  end
endmodule : wake_event_and_line_enable_logic_test
`default_nettype wire

// >>> tb/wel_line_model.sv
// Far side: line wake source and host transmit enable.
// Assumes bench strobes are sampled on clk_i.
`timescale 1ns/100ps
`default_nettype none
module wel_line_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic tx_i,
  output logic wake_o,
  output logic tx_o
);
  logic [2:0] n_q = 3'h0;
  // Wake level held a few cycles per request
  always @(posedge clk_i) begin
    n_q <= go_i ? 3'h4 : n_q - {2'h0, n_q != 3'h0};
    wake_o <= go_i || n_q > 3'h1;
    tx_o <= tx_i;
  end
endmodule : wel_line_model
`default_nettype wire
